// >>> design/mlpd_divider.sv
// Purpose: main loop variable preset divider with AXI4-Lite control
// Assumes: I_LOOP_SIGNAL is asynchronous and slower than I_CLOCK / 4
// Notes:   prescaler pulses act as the divider clock inside one domain
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module mlpd_divider
  import mlpd_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_LOOP_SIGNAL,
  output logic             O_PRESCALE_OUT,
  output logic             O_LOOP_RESET,
  output logic             O_RANK_CMD,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [3:0]  I_AWADDR,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [3:0]  I_ARADDR,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP
);
  logic        sig_meta_reg;
  logic        sig_sync_reg;
  logic        sig_prev_reg;
  logic        sig_edge;
  logic        pre_pulse;
  logic        loop_reset;
  logic [9:0]  decade_reg;
  logic [1:0]  enable_reg;
  logic        run_reg;
  logic        rank_reg;
  logic [15:0] cycles_reg;
  logic [9:0]  ctrl_reg;
  logic [3:0]  sel1m;
  logic [1:0]  sel10m;
  logic [3:0]  sel100k;
  logic        dec_in_a;
  logic        dec_in_b;
  logic        dec_in_c;
  logic        decode;
  logic        hit100k;
  logic        tap_step;
  logic        aw_have_reg;
  logic [3:0]  awaddr_reg;
  logic        w_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [3:0]  since_rst_reg;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);

  // the loop signal is asynchronous: two stages before any logic
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sig_meta_reg <= 1'b0;
      sig_sync_reg <= 1'b0;
      sig_prev_reg <= 1'b0;
    end else begin
      sig_meta_reg <= I_LOOP_SIGNAL;
      sig_sync_reg <= sig_meta_reg;
      sig_prev_reg <= sig_sync_reg;
    end
  end
  assign sig_edge = sig_sync_reg && !sig_prev_reg;

  mlpd_prescaler u_prescaler (
    .i_clock  (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_step   (sig_edge),
    .i_div12  (rank_reg),
    .o_pulse  (pre_pulse)
  );

  mlpd_oneshot u_oneshot (
    .i_clock  (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_trig   (decode),
    .i_tick   (pre_pulse),
    .o_active (loop_reset)
  );

  assign sel1m   = ctrl_reg[CTRL_SEL1M_LO +: 4];
  assign sel10m  = ctrl_reg[CTRL_SEL10M_LO +: 2];
  assign sel100k = ctrl_reg[CTRL_SEL100K_LO +: 4];

  // selector gates: xor picks true or inverted enable output
  assign dec_in_a = enable_reg[0] ^ sel10m[0];
  assign dec_in_b = enable_reg[1] ^ sel10m[1];
  // out-of-range selector never matches, so the divider never resets
  assign dec_in_c = !((sel1m < SEL_LIMIT) && decade_reg[sel1m]);
  assign hit100k  = (sel100k < SEL_LIMIT) && decade_reg[sel100k];
  // run_reg keeps the initial state from re-firing the decode
  assign decode   = run_reg && !dec_in_a && !dec_in_b && !dec_in_c;
  assign tap_step = pre_pulse && decade_reg[TAP_POS - 1] && !decode;

  // decade counter, one-hot ring
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      decade_reg <= DECADE_INIT;
    end else if (decode) begin
      decade_reg <= DECADE_INIT;
    end else if (pre_pulse) begin
      decade_reg <= {decade_reg[DECADE_N-2:0], decade_reg[DECADE_N-1]};
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      run_reg <= 1'b0;
    end else if (decode) begin
      run_reg <= 1'b0;
    end else if (pre_pulse) begin
      run_reg <= 1'b1;
    end
  end

  // enable flip-flops: a two-bit count of tap edges
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      enable_reg <= 2'h0;
    end else if (loop_reset) begin
      enable_reg <= 2'h0;
    end else if (tap_step) begin
      enable_reg <= enable_reg + 2'h1;
    end
  end

  // rank command: divide by twelve from cycle start until the 100 kHz position
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rank_reg <= 1'b1;
    end else if (decode) begin
      rank_reg <= 1'b1;
    end else if (run_reg && hit100k) begin
      rank_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cycles_reg <= 16'h0000;
    end else if (decode) begin
      cycles_reg <= cycles_reg + 16'h0001;
    end
  end

  // pulses since the last counter reset, kept apart from the ring so the tap check is independent
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      since_rst_reg <= 4'h0;
    end else if (decode) begin
      since_rst_reg <= 4'h0;
    end else if (pre_pulse) begin
      since_rst_reg <= (since_rst_reg == 4'(DECADE_N - 1)) ? 4'h0 : since_rst_reg + 4'h1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PRESCALE_OUT <= 1'b0;
      O_LOOP_RESET   <= 1'b0;
      O_RANK_CMD     <= 1'b1;
    end else begin
      O_PRESCALE_OUT <= pre_pulse;
      O_LOOP_RESET   <= loop_reset;
      O_RANK_CMD     <= rank_reg;
    end
  end

  // axi write: address and data taken in either order
  assign wr_fire = aw_have_reg && w_have_reg && !O_BVALID;

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_AWREADY   <= 1'b1;
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 4'h0;
    end else if (O_AWREADY && I_AWVALID) begin
      O_AWREADY   <= 1'b0;
      aw_have_reg <= 1'b1;
      awaddr_reg  <= I_AWADDR;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end else if (O_BVALID && I_BREADY) begin
      O_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_WREADY   <= 1'b1;
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (O_WREADY && I_WVALID) begin
      O_WREADY   <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg  <= I_WDATA;
      wstrb_reg  <= I_WSTRB;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end else if (O_BVALID && I_BREADY) begin
      O_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= (awaddr_reg == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && awaddr_reg == REG_CTRL) begin
      if (wstrb_reg[0]) begin
        ctrl_reg[7:0] <= wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
        ctrl_reg[9:8] <= wdata_reg[9:8];
      end
    end
  end

  // axi read: status shows live divider state
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (I_ARADDR)
      REG_CTRL: begin
        rd_mux[CTRL_WIDTH-1:0] = ctrl_reg;
      end
      REG_STATUS: begin
        rd_mux[DECADE_N-1:0]              = decade_reg;
        rd_mux[STAT_ENABLE_LO +: 2]       = enable_reg;
        rd_mux[STAT_LOOP_RST]             = loop_reset;
        rd_mux[STAT_RANK]                 = rank_reg;
      end
      REG_CYCLES: begin
        rd_mux[15:0] = cycles_reg;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= RESP_OKAY;
    end else if (O_ARREADY && I_ARVALID) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_mux;
      O_RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  a_onehot_decade: assert property ($onehot(decade_reg))
    else $error("decade counter not one-hot");
  a_decade_steps: assert property ((pre_pulse && !decode) |=> decade_reg == {$past(decade_reg[8:0]), $past(decade_reg[9])})
    else $error("decade counter did not step on prescaler pulse");
  a_tap_second: assert property ((pre_pulse && !decode && since_rst_reg == 4'(TAP_POS - 1))
                                 |=> decade_reg[TAP_POS])
    else $error("tap not high on second pulse after reset");
  a_tap_counts: assert property ((tap_step && !loop_reset) |=> enable_reg == $past(enable_reg) + 2'h1)
    else $error("enable flip-flops missed a tap");
  a_decode_match: assert property (decode |-> (enable_reg == sel10m && decade_reg[sel1m] && sel1m < SEL_LIMIT))
    else $error("decode without matching selectors");
  a_decode_clears: assert property (decode |=> (decade_reg == DECADE_INIT && !run_reg && rank_reg))
    else $error("decode did not restore initial state");
  a_reset_pulse: assert property (decode |=> loop_reset ##1 O_LOOP_RESET)
    else $error("loop cycle reset not raised after decode");
  a_enable_held: assert property (loop_reset |=> enable_reg == 2'h0)
    else $error("enable flip-flops not cleared during reset");
  a_no_early_dec: assert property ((!run_reg && !pre_pulse) |=> !decode)
    else $error("decode fired in initial state");

  c_full_cycle: cover property (decode ##[1:1000] decode);
  c_high_band: cover property (decode && sel10m == 2'h2);
  c_rank_drop: cover property (rank_reg ##1 !rank_reg);
  c_write_ctrl: cover property (wr_fire && awaddr_reg == REG_CTRL);
endmodule : mlpd_divider

// >>> common/mlpd_pkg.sv
// Purpose: shared constants of the main loop preset divider
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes:   register offsets are byte addresses
package mlpd_pkg;
  localparam int          CLK_HZ        = 25_000_000;
  // register map
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_CYCLES    = 4'h8;
  // control fields
  localparam int          CTRL_SEL1M_LO   = 0;
  localparam int          CTRL_SEL10M_LO  = 4;
  localparam int          CTRL_SEL100K_LO = 6;
  localparam int          CTRL_WIDTH      = 10;
  localparam logic [9:0]  CTRL_RESET      = 10'h000;
  // status fields
  localparam int          STAT_ENABLE_LO  = 10;
  localparam int          STAT_LOOP_RST   = 12;
  localparam int          STAT_RANK       = 13;
  // decade counter
  localparam int          DECADE_N      = 10;
  localparam logic [9:0]  DECADE_INIT   = 10'h001;
  localparam int          TAP_POS       = 2;
  localparam logic [3:0]  SEL_LIMIT     = 4'ha;
  // prescaler
  localparam logic [3:0]  PRE_LAST10    = 4'h9;
  localparam logic [3:0]  PRE_LAST12    = 4'hb;
  // one-shot length in prescaler pulses
  localparam logic [2:0]  ONESHOT_TICKS = 3'h1;
  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : mlpd_pkg

// >>> design/mlpd_prescaler.sv
// Purpose: dual-modulus divide by ten or twelve
// Assumes: i_step is a one-cycle pulse per input edge
// Notes:   modulus follows the rank command at every input step, not latched at the wrap
`timescale 1ns/100ps
module mlpd_prescaler
  import mlpd_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_step,
  input  wire logic i_div12,
  output logic      o_pulse
);
  logic [3:0] cnt_reg;
  logic [3:0] last;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  assign last = i_div12 ? PRE_LAST12 : PRE_LAST10;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 4'h0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      if (i_step) begin
        if (cnt_reg >= last) begin
          cnt_reg <= 4'h0;
          o_pulse <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end

  a_wrap_twelve: assert property ((i_step && i_div12 && cnt_reg == PRE_LAST12) |=> (o_pulse && cnt_reg == 4'h0))
    else $error("prescaler did not wrap after twelve steps");
  a_no_early_ten: assert property ((i_step && !i_div12 && cnt_reg < PRE_LAST10) |=> !o_pulse)
    else $error("prescaler pulsed before ten steps");
endmodule : mlpd_prescaler

// >>> design/mlpd_oneshot.sv
// Purpose: synchronous stretcher of the loop cycle reset
// Assumes: i_tick is the prescaler output pulse
// Notes:   length counted in prescaler pulses
`timescale 1ns/100ps
module mlpd_oneshot
  import mlpd_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_trig,
  input  wire logic i_tick,
  output logic      o_active
);
  logic [2:0] cnt_reg;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_active <= 1'b0;
      cnt_reg  <= 3'h0;
    end else if (i_trig) begin
      o_active <= 1'b1;
      cnt_reg  <= ONESHOT_TICKS;
    end else if (o_active && i_tick) begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1) begin
        o_active <= 1'b0;
      end
    end
  end

  a_trig_starts: assert property (i_trig |=> (o_active && cnt_reg == ONESHOT_TICKS))
    else $error("one-shot did not start on trigger");
  a_holds_no_tick: assert property ((o_active && !i_tick && !i_trig) |=> o_active)
    else $error("one-shot dropped without a tick");
endmodule : mlpd_oneshot

// >>> verif/mlpd_loop_source.sv
// Purpose: loop signal source feeding the divider prescaler input
// Assumes: runs in the bench clock domain
// Notes:   idles low between runs; slow mode stretches each half period
`timescale 1ns/100ps
module mlpd_loop_source (
  input  wire logic i_clock,
  input  wire logic i_run,
  input  wire logic i_slow,
  output logic      o_loop = 1'b0
);
  logic [3:0] half_cnt_reg = 4'h0;
  always @(posedge i_clock) begin
    if (!i_run) begin
      half_cnt_reg <= 4'h0;
      o_loop       <= 1'b0;
    end else if (half_cnt_reg == (i_slow ? 4'h8 : 4'h4)) begin
      // levels last five cycles or more so the synchroniser never misses one
      half_cnt_reg <= 4'h0;
      o_loop       <= ~o_loop;
    end else begin
      half_cnt_reg <= half_cnt_reg + 4'h1;
    end
  end
endmodule : mlpd_loop_source

// >>> verif/mlpd_divider_tb.sv
// Purpose: self-checking bench of the main loop preset divider
// Assumes: loop source model drives the prescaler input
// Notes:   each scenario starts from a fresh hardware reset
`timescale 1ns/100ps
module mlpd_divider_tb
  import mlpd_pkg::*;
;
  logic        I_CLOCK, I_ARST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [3:0]  I_AWADDR, I_WSTRB, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA;
  logic        I_LOOP_SIGNAL, O_PRESCALE_OUT, O_LOOP_RESET, O_RANK_CMD;
  logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0]  O_BRESP, O_RRESP;
  logic        run, slow, loop_d;
  int          err_count, n_compared, pulse_cnt, edge_cnt, gap;

  mlpd_loop_source SRC (.i_clock(I_CLOCK), .i_run(run), .i_slow(slow), .o_loop(I_LOOP_SIGNAL));
  mlpd_divider DUT (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_LOOP_SIGNAL(I_LOOP_SIGNAL),
    .O_PRESCALE_OUT(O_PRESCALE_OUT), .O_LOOP_RESET(O_LOOP_RESET), .O_RANK_CMD(O_RANK_CMD),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .O_BVALID(O_BVALID),
    .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .I_ARADDR(I_ARADDR), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP));

  initial begin
    I_CLOCK = 1'b0;
    forever #20 I_CLOCK = ~I_CLOCK;
  end

  // loop edges between prescaler pulses; latency is fixed so the gap is exact
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pulse_cnt <= 0;
      edge_cnt  <= 0;
      gap       <= 0;
      loop_d    <= 1'b0;
    end else begin
      loop_d <= I_LOOP_SIGNAL;
      if (O_PRESCALE_OUT) begin
        pulse_cnt <= pulse_cnt + 1;
        gap       <= edge_cnt;
        edge_cnt  <= int'(I_LOOP_SIGNAL && !loop_d);
      end else begin
        edge_cnt <= edge_cnt + int'(I_LOOP_SIGNAL && !loop_d);
      end
    end
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stall();
    err_count++;
    complete_run();
  endtask : stall

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    @(posedge I_CLOCK);
    I_AWVALID <= 1'b1;
    I_AWADDR  <= a;
    I_WVALID  <= 1'b1;
    I_WDATA   <= d;
    I_WSTRB   <= s;
    I_BREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CLOCK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID === 1'b1 && I_BREADY) begin
        r = O_BRESP;
        I_BREADY <= 1'b0;
        break;
      end
    end
    if (n >= 50) stall();
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge I_CLOCK);
    I_ARVALID <= 1'b1;
    I_ARADDR  <= a;
    I_RREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CLOCK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID === 1'b1 && I_RREADY) begin
        d = O_RDATA;
        r = O_RRESP;
        I_RREADY <= 1'b0;
        break;
      end
    end
    if (n >= 50) stall();
  endtask : axi_read

  task automatic reg_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, e);
    check(r, er);
  endtask : reg_chk

  task automatic do_reset();
    @(posedge I_CLOCK);
    run      <= 1'b0;
    slow     <= 1'b0;
    I_ARST_N <= 1'b0;
    repeat (8) @(posedge I_CLOCK);
    I_ARST_N <= 1'b1;
    @(posedge I_CLOCK);
  endtask : do_reset

  task automatic ctrl_set(input logic [31:0] v);
    logic [1:0] r;
    axi_write(REG_CTRL, v, 4'hf, r);
    check(r, RESP_OKAY);
    run <= 1'b1;
  endtask : ctrl_set

  task automatic wait_pulses(input int k);
    int n;
    for (n = 0; n < 3000 && pulse_cnt < k; n++) @(posedge I_CLOCK);
    if (pulse_cnt < k) stall();
  endtask : wait_pulses

  // two extra edges let the bench pulse counter catch up with the output
  task automatic wait_lr(input logic v);
    int n;
    for (n = 0; n < 6000 && O_LOOP_RESET !== v; n++) @(posedge I_CLOCK);
    if (O_LOOP_RESET !== v) stall();
    repeat (2) @(posedge I_CLOCK);
  endtask : wait_lr

  task automatic s_regs();
    logic [1:0] r;
    do_reset();
    check({O_LOOP_RESET, O_RANK_CMD, O_PRESCALE_OUT}, 3'b010);
    reg_chk(REG_CTRL, 32'h0, RESP_OKAY);
    reg_chk(REG_STATUS, 32'h0000_2001, RESP_OKAY);
    reg_chk(REG_CYCLES, 32'h0, RESP_OKAY);
    reg_chk(4'hc, 32'h0, RESP_SLVERR);
    axi_write(REG_STATUS, 32'hffff_ffff, 4'hf, r);
    check(r, RESP_SLVERR);
    reg_chk(REG_STATUS, 32'h0000_2001, RESP_OKAY);
    axi_write(REG_CTRL, 32'hffff_ffff, 4'h1, r);
    reg_chk(REG_CTRL, 32'h0000_00ff, RESP_OKAY);
    axi_write(REG_CTRL, 32'hffff_ffff, 4'h2, r);
    reg_chk(REG_CTRL, 32'h0000_03ff, RESP_OKAY);
  endtask : s_regs

  // selectors that never match: the counter free-runs at divide by twelve
  task automatic s_count();
    logic [31:0] d;
    logic [1:0]  r;
    do_reset();
    ctrl_set(32'h0000_03cf);
    for (int k = 1; k <= 12; k++) begin
      wait_pulses(k);
      axi_read(REG_STATUS, d, r);
      check(32'(d[9:0]), 32'h1 << (k % 10));
      check(32'(d[11:10]), 32'((k + 8) / 10));
      if (k > 1) check(gap, 12);
    end
    check(O_LOOP_RESET, 1'b0);
    check(O_RANK_CMD, 1'b1);
  endtask : s_count

  task automatic s_div10();
    do_reset();
    ctrl_set(32'h0000_004f);
    slow <= 1'b1;
    wait_pulses(4);
    check(gap, 10);
    check(O_RANK_CMD, 1'b0);
  endtask : s_div10

  task automatic s_cycle(input logic [1:0] t, input logic [3:0] p, input int n);
    logic [31:0] d;
    logic [1:0]  r;
    int          c0;
    do_reset();
    ctrl_set({22'h0, 4'hf, t, p});
    wait_lr(1'b1);
    check(pulse_cnt, n);
    c0 = pulse_cnt;
    axi_read(REG_STATUS, d, r);
    check(32'(d[12:10]), 32'h4);
    wait_lr(1'b0);
    check(pulse_cnt - c0, ONESHOT_TICKS);
    wait_lr(1'b1);
    check(pulse_cnt - c0, n);
    reg_chk(REG_CYCLES, 32'h2, RESP_OKAY);
  endtask : s_cycle

  initial begin
    I_ARST_N  = 1'b0;
    I_AWVALID = 1'b0;
    I_WVALID  = 1'b0;
    I_BREADY  = 1'b0;
    I_ARVALID = 1'b0;
    I_RREADY  = 1'b0;
    I_AWADDR  = 4'h0;
    I_ARADDR  = 4'h0;
    I_WSTRB   = 4'h0;
    I_WDATA   = 32'h0;
    run       = 1'b0;
    slow      = 1'b0;
    err_count  = 0;
    n_compared = 0;
    s_regs();
    s_count();
    s_div10();
    s_cycle(2'h1, 4'h0, 10);
    s_cycle(2'h1, 4'h1, 11);
    s_cycle(2'h2, 4'h5, 15);
    s_cycle(2'h0, 4'h1, 1);
    complete_run();
  end
endmodule : mlpd_divider_tb
